// >>> rtl/cptmr_pkg.sv
package cptmr_pkg;
  // ---------------------------------------------------------------
  // register word offsets (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_P1_DIR   = 8'h00;
  localparam logic [7:0] OFS_P2_DIR   = 8'h01;
  localparam logic [7:0] OFS_P1_VAL   = 8'h02;
  localparam logic [7:0] OFS_P2_VAL   = 8'h03;
  localparam logic [7:0] OFS_TCS      = 8'h08;
  localparam logic [7:0] OFS_FRC_HI   = 8'h09;
  localparam logic [7:0] OFS_FRC_LO   = 8'h0a;
  localparam logic [7:0] OFS_OCMP_HI  = 8'h0b;
  localparam logic [7:0] OFS_OCMP_LO  = 8'h0c;
  localparam logic [7:0] OFS_CAP_HI   = 8'h0d;
  localparam logic [7:0] OFS_CAP_LO   = 8'h0e;
  localparam logic [7:0] OFS_SER_CTL  = 8'h11;
  localparam logic [7:0] OFS_P5_SEL   = 8'h43;
  localparam logic [7:0] OFS_MODE     = 8'h80;
  // ---------------------------------------------------------------
  // control/status field positions
  // ---------------------------------------------------------------
  localparam int unsigned TCS_CAP_FLAG = 7;
  localparam int unsigned TCS_CMP_FLAG = 6;
  localparam int unsigned TCS_OVF_FLAG = 5;
  localparam int unsigned TCS_CAP_IEN  = 4;
  localparam int unsigned TCS_CMP_IEN  = 3;
  localparam int unsigned TCS_OVF_IEN  = 2;
  localparam int unsigned TCS_EDGE     = 1;
  localparam int unsigned TCS_OUTPUT_LEVEL_BIT     = 0;
  localparam int unsigned SER_RX_EN    = 3;
  localparam int unsigned SER_TX_EN    = 1;
  localparam int unsigned P5_TWI_SEL   = 2;
  localparam int unsigned P2_CAP_BIT   = 0;
  localparam int unsigned P2_BAUD_BIT  = 2;
  localparam int unsigned P2_RX_BIT    = 3;
  localparam int unsigned P2_TX_BIT    = 4;
  localparam int unsigned P1_TWI_LO    = 3;
  localparam int unsigned P1_TWI_HI    = 4;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_P1_DIR  = 8'h00;
  localparam logic [4:0]  RST_P2_DIR  = 5'h00;
  localparam logic [7:0]  RST_P1_VAL  = 8'h00;
  localparam logic [4:0]  RST_P2_VAL  = 5'h00;
  localparam logic [4:0]  RST_TCS_CTL = 5'h00;
  localparam logic [15:0] RST_FRC     = 16'h0000;
  localparam logic [15:0] RST_OCMP    = 16'hffff;
  localparam logic [15:0] RST_CAP     = 16'h0000;
  localparam logic [7:0]  RST_SER_CTL = 8'h00;
  localparam logic [7:0]  RST_P5_SEL  = 8'h00;
  localparam logic [31:0] BUS_UNMAPPED = 32'h0000_0000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned BUS_CLK_KHZ_SLOW = 1008;
  localparam int unsigned BUS_CLK_KHZ_FAST = 2016;
  localparam int unsigned SYS_CLK_KHZ      = 100000;
  localparam logic [7:0]  TICK_DIV_SLOW    = 8'(SYS_CLK_KHZ / BUS_CLK_KHZ_SLOW - 1);
  localparam logic [7:0]  TICK_DIV_FAST    = 8'(SYS_CLK_KHZ / BUS_CLK_KHZ_FAST - 1);
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] dat;
  } cptmr_wb_req_t;

  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } cptmr_pins_t;
endpackage

// >>> rtl/cptmr_top.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Notes on behaviour
// ---------------------------------------------------------------
// Notes on behaviour
// - eight-bit port one, each line steered by its direction bit, data register.
// - direction 1 is output, 0 input; both direction registers clear on reset.
// - port one drivers off for input lines and off on every line during reset.
// - port one lines 3 and 4 go to two-wire controller when select bit set.
// - port one never carries low address bits.
// - port two is five bits; only bits 3 and 4 reach pins.
// - serial rx/tx enables override port two direction only; output data still comes from the data register.
// - bus clock 1.008 or 2.016 MHz, undivided; core rate follows it.
// - 16-bit free-running counter steps once per bus clock cycle.
// - capture input wired internally to the frequency-counter output.
// - qualifying capture edge copies counter into read-only capture register.
// - control bit 1 picks edge: 0 falling, 1 rising.
// - status bit 7 sets on capture, clears on capture register read.
// - status bit 5 sets on overflow, clears on counter read.
// - bits 4 and 2 enable capture and overflow interrupt requests.
// - no waveform; compare flag, its enable and output level do nothing.
// - counter writable; double-byte store loads both bytes together.
// - reading the counter leaves the count and counting untouched.
// - in emulation mode the core's outputs leave the internal buses undriven.
module cptmr_top
  import cptmr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        emul_mode_i,
  input  wire logic        turbo_i,
  input  wire logic        freq_counter_i,
  input  wire logic        baud_clk_i,
  input  wire logic [7:0]  p1_pin_i,
  output logic      [7:0]  p1_pin_o,
  output logic      [7:0]  p1_pin_oe_o,
  input  wire logic [1:0]  p2_pin_i,
  output logic      [1:0]  p2_pin_o,
  output logic      [1:0]  p2_pin_oe_o,
  output logic             twi_port_sel_o,
  output logic             irq_o
);
  import cptmr_pkg::*;

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [12:0] sync1_r;
  logic [12:0] sync2_r;
  logic [12:0] async_in;
  assign async_in = {emul_mode_i, freq_counter_i, baud_clk_i, p2_pin_i, p1_pin_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_r <= 13'h0000;
      sync2_r <= 13'h0000;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  logic [7:0] p1_in;
  logic [1:0] p2_in_pins;
  logic       baud_in;
  logic       cap_src;
  logic       emul_in;
  assign emul_in    = sync2_r[12];
  assign p1_in      = sync2_r[7:0];
  assign p2_in_pins = sync2_r[9:8];
  assign baud_in    = sync2_r[10];
  assign cap_src    = sync2_r[11];

  // ---------------------------------------------------------------
  // bus clock tick
  // ---------------------------------------------------------------
  logic [7:0] div_r;
  logic       tick;
  // >= so a rate change mid-count never lets the divider run past its end
  assign tick = (div_r >= (turbo_i ? TICK_DIV_FAST : TICK_DIV_SLOW));

  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic       req;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic [7:0] wbyte;
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr    = req && wb_we_i && wb_sel_i[0];
  assign rd    = req && !wb_we_i;
  assign idx   = wb_adr_i[9:2];
  assign wbyte = wb_dat_i[7:0];

  // ---------------------------------------------------------------
  // port registers
  // ---------------------------------------------------------------
  logic [7:0] p1_dir_r;
  logic [4:0] p2_dir_r;
  logic [7:0] p1_val_r;
  logic [4:0] p2_val_r;
  logic [7:0] ser_ctl_r;
  logic [7:0] p5_sel_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1_dir_r <= RST_P1_DIR;
      p2_dir_r <= RST_P2_DIR;
    end else if (wr && idx == OFS_P1_DIR) begin
      p1_dir_r <= wbyte;
    end else if (wr && idx == OFS_P2_DIR) begin
      p2_dir_r <= wbyte[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1_val_r  <= RST_P1_VAL;
      p2_val_r  <= RST_P2_VAL;
      ser_ctl_r <= RST_SER_CTL;
      p5_sel_r  <= RST_P5_SEL;
    end else if (wr && idx == OFS_P1_VAL) begin
      p1_val_r <= wbyte;
    end else if (wr && idx == OFS_P2_VAL) begin
      p2_val_r <= wbyte[4:0];
    end else if (wr && idx == OFS_SER_CTL) begin
      ser_ctl_r <= wbyte;
    end else if (wr && idx == OFS_P5_SEL) begin
      p5_sel_r <= wbyte;
    end
  end

  // effective port two direction after serial override
  logic [4:0] p2_dir_eff;
  always_comb begin
    p2_dir_eff = p2_dir_r;
    if (ser_ctl_r[SER_RX_EN]) begin
      p2_dir_eff[P2_RX_BIT] = 1'b0;
    end
    if (ser_ctl_r[SER_TX_EN]) begin
      p2_dir_eff[P2_TX_BIT] = 1'b1;
    end
  end

  // port two input view: internal sources on bits 0 and 2, bit 1 open
  logic [4:0] p2_in;
  assign p2_in = {p2_in_pins, baud_in, 1'b0, cap_src};

  logic twi_sel;
  assign twi_sel = p5_sel_r[P5_TWI_SEL];

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  logic [7:0] p1_oe_nxt;
  always_comb begin
    p1_oe_nxt = p1_dir_r;
    if (twi_sel) begin
      p1_oe_nxt[P1_TWI_HI:P1_TWI_LO] = 2'b00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p1_pin_o       <= 8'h00;
      p1_pin_oe_o    <= 8'h00;
      p2_pin_o       <= 2'b00;
      p2_pin_oe_o    <= 2'b00;
      twi_port_sel_o <= 1'b0;
    end else begin
      p1_pin_o       <= p1_val_r;
      p1_pin_oe_o    <= p1_oe_nxt;
      p2_pin_o       <= p2_val_r[P2_TX_BIT:P2_RX_BIT];
      p2_pin_oe_o    <= p2_dir_eff[P2_TX_BIT:P2_RX_BIT];
      twi_port_sel_o <= twi_sel;
    end
  end

  // ---------------------------------------------------------------
  // timer
  // ---------------------------------------------------------------
  logic [15:0] frc_r;
  logic [15:0] cap_r;
  logic [15:0] ocmp_r;
  logic [4:0]  tcs_ctl_r;
  logic        cap_flag_r;
  logic        ovf_flag_r;
  logic        cmp_flag_r;
  logic        cap_prev_r;
  logic        cap_edge;
  logic        ovf_evt;
  logic        frc_wr;
  logic        frc_rd;
  logic        cap_rd;

  assign cap_edge = tcs_ctl_r[TCS_EDGE] ? (cap_src && !cap_prev_r)
                                        : (!cap_src && cap_prev_r);
  assign ovf_evt  = tick && (frc_r == 16'hffff) && !frc_wr;
  assign frc_wr   = wr && (idx == OFS_FRC_HI);
  assign frc_rd   = rd && (idx == OFS_FRC_HI || idx == OFS_FRC_LO);
  assign cap_rd   = rd && (idx == OFS_CAP_HI || idx == OFS_CAP_LO);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_prev_r <= 1'b0;
    end else begin
      cap_prev_r <= cap_src;
    end
  end

  // one word write to the high index loads both bytes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frc_r <= RST_FRC;
    end else if (frc_wr) begin
      frc_r <= wb_dat_i[15:0];
    end else if (tick) begin
      frc_r <= frc_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_r <= RST_CAP;
    end else if (cap_edge) begin
      cap_r <= frc_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tcs_ctl_r <= RST_TCS_CTL;
      ocmp_r    <= RST_OCMP;
    end else if (wr && idx == OFS_TCS) begin
      tcs_ctl_r <= wbyte[4:0];
    end else if (wr && idx == OFS_OCMP_HI) begin
      ocmp_r <= wb_dat_i[15:0];
    end
  end

  // set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_flag_r <= 1'b0;
    end else if (cap_edge) begin
      cap_flag_r <= 1'b1;
    end else if (cap_rd) begin
      cap_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_flag_r <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_r <= 1'b1;
    end else if (frc_rd) begin
      ovf_flag_r <= 1'b0;
    end
  end

  // compare never raises a flag: no waveform output exists
  always_ff @(posedge clk_i) begin
    cmp_flag_r <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= (cap_flag_r && tcs_ctl_r[TCS_CAP_IEN])
            || (ovf_flag_r && tcs_ctl_r[TCS_OVF_IEN]);
    end
  end

  // ---------------------------------------------------------------
  // read mux and ack
  // ---------------------------------------------------------------
  logic [31:0] rdata;
  always_comb begin
    rdata = BUS_UNMAPPED;
    if (idx == OFS_P1_VAL) begin
      rdata[7:0] = (p1_val_r & p1_dir_r) | (p1_in & ~p1_dir_r);
    end else if (idx == OFS_P2_VAL) begin
      rdata[4:0] = (p2_val_r & p2_dir_eff) | (p2_in & ~p2_dir_eff);
    end else if (idx == OFS_TCS) begin
      rdata[7:0] = {cap_flag_r, cmp_flag_r, ovf_flag_r, tcs_ctl_r};
    end else if (idx == OFS_FRC_HI) begin
      rdata[15:0] = frc_r;
    end else if (idx == OFS_FRC_LO) begin
      rdata[7:0] = frc_r[7:0];
    end else if (idx == OFS_OCMP_HI) begin
      rdata[15:0] = ocmp_r;
    end else if (idx == OFS_OCMP_LO) begin
      rdata[7:0] = ocmp_r[7:0];
    end else if (idx == OFS_CAP_HI) begin
      rdata[15:0] = cap_r;
    end else if (idx == OFS_CAP_LO) begin
      rdata[7:0] = cap_r[7:0];
    end else if (idx == OFS_SER_CTL) begin
      rdata[7:0] = ser_ctl_r;
    end else if (idx == OFS_P5_SEL) begin
      rdata[7:0] = p5_sel_r;
    end else if (idx == OFS_MODE) begin
      rdata[1:0] = {turbo_i, emul_in};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd && !emul_in) begin
        wb_dat_o <= rdata;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_RST_DIR: assert property (@(posedge clk_i) rst_i |=> p1_dir_r == 8'h00 && p2_dir_r == 5'h00)
    else $error("direction not cleared by reset");
  AST_OE_RST: assert property (@(posedge clk_i) rst_i |=> p1_pin_oe_o == 8'h00)
    else $error("port one driven during reset");
  AST_TWI: assert property (@(posedge clk_i) disable iff (rst_i)
    twi_sel |=> p1_pin_oe_o[4:3] == 2'b00)
    else $error("twi lines still driven by port");
  AST_TX_OVR: assert property (@(posedge clk_i) disable iff (rst_i)
    ser_ctl_r[SER_TX_EN] |=> p2_pin_oe_o[1])
    else $error("tx enable did not force output");
  AST_RX_OVR: assert property (@(posedge clk_i) disable iff (rst_i)
    ser_ctl_r[SER_RX_EN] |=> !p2_pin_oe_o[0])
    else $error("rx enable did not force input");
  AST_FRC_INC: assert property (@(posedge clk_i) disable iff (rst_i)
    tick && !frc_wr |=> frc_r == $past(frc_r) + 16'h0001)
    else $error("counter did not step");
  AST_FRC_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    !tick && !frc_wr |=> $stable(frc_r))
    else $error("counter moved without a tick");
  AST_CAP: assert property (@(posedge clk_i) disable iff (rst_i)
    cap_edge |=> cap_r == $past(frc_r) && cap_flag_r)
    else $error("capture missed");
  AST_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    cap_edge |-> cap_src == tcs_ctl_r[TCS_EDGE])
    else $error("capture on wrong edge");
  AST_CAPCLR: assert property (@(posedge clk_i) disable iff (rst_i)
    cap_rd && !cap_edge |=> !cap_flag_r)
    else $error("capture flag not cleared");
  AST_OVF: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_evt |=> ovf_flag_r && frc_r == 16'h0000)
    else $error("overflow flag not set");
  AST_FRC_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    frc_wr |=> frc_r == $past(wb_dat_i[15:0]))
    else $error("counter load failed");
  AST_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == $past((cap_flag_r && tcs_ctl_r[TCS_CAP_IEN]) || (ovf_flag_r && tcs_ctl_r[TCS_OVF_IEN])))
    else $error("irq disagrees with flags");
  AST_EMUL: assert property (@(posedge clk_i) disable iff (rst_i)
    emul_in |=> wb_dat_o == 32'h0000_0000)
    else $error("bus driven in emulation mode");
  AST_NOCMP: assert property (@(posedge clk_i) disable iff (rst_i) !cmp_flag_r)
    else $error("compare flag raised");
  AST_TICK: assert property (@(posedge clk_i) disable iff (rst_i) div_r <= TICK_DIV_SLOW)
    else $error("divider out of range");
endmodule

// >>> dv/cptmr_cpu_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// processor core stand-in: classic single-cycle bus master
// ---------------------------------------------------------------
module cptmr_cpu_model (
  input  wire logic               clk_i,
  input  wire logic [31:0]        wb_dat_i,
  input  wire logic               wb_ack_i,
  output cptmr_pkg::cptmr_wb_req_t req_o
);
  import cptmr_pkg::*;

  initial req_o = '0;

  // hold the request until ack is sampled, then idle one cycle
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] q);
    req_o <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: {idx, 2'b00}, dat: d};
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1) begin
      @(posedge clk_i);
    end
    q = wb_dat_i;
    req_o <= '0;
    @(posedge clk_i);
  endtask
endmodule

// >>> dv/cptmr_test.sv
`timescale 1ns/1ps
module cptmr_test;
  import cptmr_pkg::*;
  logic          clk_i, rst_i, emul_mode_i, turbo_i, freq_counter_i, baud_clk_i;
  logic [7:0]    p1_pin_i, p1_pin_o, p1_pin_oe_o;
  logic [1:0]    p2_pin_i, p2_pin_o, p2_pin_oe_o;
  logic [31:0]   wb_dat_o, q, c0;
  logic          wb_ack_o, twi_port_sel_o, irq_o;
  cptmr_wb_req_t req;
  int            bad_count, samples_checked;

  cptmr_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .emul_mode_i(emul_mode_i),
    .turbo_i(turbo_i), .freq_counter_i(freq_counter_i), .baud_clk_i(baud_clk_i),
    .p1_pin_i(p1_pin_i), .p1_pin_o(p1_pin_o), .p1_pin_oe_o(p1_pin_oe_o),
    .p2_pin_i(p2_pin_i), .p2_pin_o(p2_pin_o), .p2_pin_oe_o(p2_pin_oe_o),
    .twi_port_sel_o(twi_port_sel_o), .irq_o(irq_o)
  );
  cptmr_cpu_model cpu (.clk_i(clk_i), .wb_dat_i(wb_dat_o), .wb_ack_i(wb_ack_o), .req_o(req));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    cpu.xfer(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [7:0] idx);
    cpu.xfer(1'b0, idx, 32'h0, q);
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    chk("p1 oe in reset", 32'h0, {24'h0, p1_pin_oe_o});
    rst_i <= 1'b0;
    ticks(1);
    rd(OFS_P1_DIR);
    chk("p1 dir read", 32'h0, q);
    rd(OFS_TCS);
    chk("tcs reset", 32'h0, q);
    rd(8'h20);
    chk("unmapped read", 32'h0, q);
  endtask

  task automatic t_port_one;
    p1_pin_i <= 8'h3c;
    wr(OFS_P1_DIR, 32'hf0);
    wr(OFS_P1_VAL, 32'ha5);
    chk("p1 oe", 32'hf0, {24'h0, p1_pin_oe_o});
    chk("p1 out", 32'ha0, {24'h0, p1_pin_o & p1_pin_oe_o});
    rd(OFS_P1_VAL);
    chk("p1 read", 32'hac, q);
    wr(OFS_P5_SEL, 32'h04);
    chk("twi sel", 32'h1, {31'h0, twi_port_sel_o});
    chk("p1 oe twi", 32'he0, {24'h0, p1_pin_oe_o});
    wr(OFS_P5_SEL, 32'h00);
    chk("twi off", 32'h0, {31'h0, twi_port_sel_o});
    chk("p1 oe twi off", 32'hf0, {24'h0, p1_pin_oe_o});
    // mode pin passes two flip-flops before the read path sees it
    emul_mode_i <= 1'b1;
    ticks(3);
    rd(OFS_P1_VAL);
    chk("emulation read", 32'h0, q);
    emul_mode_i <= 1'b0;
    ticks(3);
  endtask

  task automatic t_port_two;
    baud_clk_i <= 1'b1;
    p2_pin_i   <= 2'b01;
    wr(OFS_P2_DIR, 32'h18); // capture and baud bits stay inputs
    wr(OFS_P2_VAL, 32'h10);
    chk("p2 oe", 32'h3, {30'h0, p2_pin_oe_o});
    chk("p2 out", 32'h2, {30'h0, p2_pin_o});
    wr(OFS_SER_CTL, 32'h08);
    chk("p2 oe rx", 32'h2, {30'h0, p2_pin_oe_o});
    wr(OFS_P2_DIR, 32'h00);
    wr(OFS_SER_CTL, 32'h02);
    chk("p2 oe tx", 32'h2, {30'h0, p2_pin_oe_o});
    wr(OFS_SER_CTL, 32'h00);
    chk("p2 oe idle", 32'h0, {30'h0, p2_pin_oe_o});
    // pins 4:3 = 01, baud source high, capture source low
    rd(OFS_P2_VAL);
    chk("p2 input view", 32'h0c, q);
  endtask

  // read interval is an exact multiple of the tick period
  task automatic t_rate(input logic fast, input int per);
    turbo_i <= fast;
    wr(OFS_FRC_HI, 32'h1000);
    rd(OFS_FRC_HI);
    c0 = {16'h0, q[15:0]};
    chk("count load", 32'h1000, c0 & 32'hfffe);
    ticks(per * 4 - 3);
    rd(OFS_FRC_HI);
    chk("count step", c0 + 4, {16'h0, q[15:0]});
  endtask

  task automatic t_overflow;
    wr(OFS_TCS, 32'h04);
    wr(OFS_FRC_HI, 32'hffff);
    ticks(60);
    chk("irq overflow", 32'h1, {31'h0, irq_o});
    rd(OFS_TCS);
    chk("tcs overflow", 32'h24, q);
    rd(OFS_FRC_LO);
    rd(OFS_TCS);
    chk("tcs ovf cleared", 32'h04, q);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    wr(OFS_TCS, 32'h00);
    wr(OFS_FRC_HI, 32'hffff);
    ticks(60);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    rd(OFS_FRC_HI);
  endtask

  task automatic edge_to(input logic lvl, input logic [31:0] tcs);
    freq_counter_i <= lvl;
    ticks(8);
    rd(OFS_TCS);
    chk("tcs after edge", tcs, q);
  endtask

  task automatic t_capture;
    wr(OFS_TCS, 32'h12);
    rd(OFS_FRC_HI);
    c0 = q;
    edge_to(1'b1, 32'h92);
    chk("irq capture", 32'h1, {31'h0, irq_o});
    rd(OFS_CAP_HI);
    chk("capture value", 32'h0, {31'h0, (q[15:0] - c0[15:0]) > 16'h1});
    c0 = q;
    rd(OFS_TCS);
    chk("tcs cap cleared", 32'h12, q);
    wr(OFS_CAP_HI, 32'h5555);
    rd(OFS_CAP_HI);
    chk("capture read only", c0, q);
    edge_to(1'b0, 32'h12);
    wr(OFS_TCS, 32'h10);
    edge_to(1'b1, 32'h10);
    edge_to(1'b0, 32'h90);
    rd(OFS_CAP_LO);
    rd(OFS_TCS);
    chk("tcs cap read low", 32'h10, q);
  endtask

  task automatic t_compare;
    wr(OFS_TCS, 32'h09);
    wr(OFS_OCMP_HI, 32'h0002);
    wr(OFS_FRC_HI, 32'h0000);
    ticks(160);
    rd(OFS_TCS);
    chk("tcs no compare", 32'h09, q);
    chk("irq no compare", 32'h0, {31'h0, irq_o});
  endtask

  // ---------------------------------------------------------------
  // clock, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    rst_i = 1'b1;
    emul_mode_i = 1'b0;
    turbo_i = 1'b0;
    freq_counter_i = 1'b0;
    baud_clk_i = 1'b0;
    p1_pin_i = 8'h00;
    p2_pin_i = 2'b00;
    bad_count = 0;
    samples_checked = 0;
    ticks(20);
    t_reset;
    t_port_one;
    t_port_two;
    t_rate(1'b1, 49);
    t_rate(1'b0, 99);
    turbo_i <= 1'b1;
    t_overflow;
    t_capture;
    t_compare;
    conclude;
  end

  initial begin
    ticks(20000);
    bad_count++;
    $display("watchdog expired");
    conclude;
  end
endmodule
